// file: opdec_consts.vh
// constants for the opcode decode and address incrementer block
`ifndef OPDEC_CONSTS_VH
`define OPDEC_CONSTS_VH
`define OFS_INSTR 8'h00
`define OFS_CTRL 8'h04
`define OFS_INDEX 8'h08
`define OFS_MEMBUF 8'h0C
`define OFS_ADDR 8'h10
`define OFS_ARG 8'h14
`define OFS_NEXT 8'h18
`define OFS_DECODE 8'h1C
`define OFS_STATUS 8'h20
`define CTRL_FETCH 0
`define CTRL_START 1
`define CTRL_LDIDX 2
`define CTRL_ADD2NEXT 3
`define CTRL_ADD2ARG 4
`define CTRL_ADD2BUF 5
`define CTRL_OP2ARG 6
`define CTRL_IDXINC 7
`define CTRL_SHIFT 8
`define CTRL_NEXT2ADDR 9
`define CODE_06 4'h6
`define CODE_10 4'h8
`define CODE_11 4'h9
`define CODE_13 4'hB
`define CODE_17 4'hF
`define CODE_LAST_LOW 4'h5
`define VAR_3 2'h3
`define RST_INCR 1'b0
`endif

// file: opcode_decode_and_address_incrementer.v
// instruction decoder and nine-bit plus-zero/plus-one address adder behind an AHB-Lite slave
`timescale 1ns/1ns
`include "opdec_consts.vh"
module opcode_decode_and_address_incrementer (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg [3:0] rangeHit,
  output reg [3:0] digitHit,
  output reg [3:0] variantHit,
  output reg [15:0] codeHit,
  output reg shared1317,
  output reg xferEnable,
  output reg operandMode,
  output reg indexFlag,
  output reg incrSelect,
  output reg shiftDone
);

  localparam SH_IDLE = 3'b001;
  localparam SH_LOAD = 3'b010;
  localparam SH_STORE = 3'b100;

  function [3:0] dec2;
    input [1:0] v;
    begin
      dec2 = 4'h1 << v;
    end
  endfunction

  function wrHit;
    input pend;
    input [7:0] ofs;
    input [7:0] target;
    begin
      wrHit = pend && ofs == target;
    end
  endfunction

  reg [5:0] opcodeHold_q;
  reg [8:0] operandField_q;
  reg [8:0] indexWord_q;
  reg [14:0] memBuf_q;
  reg [8:0] addrLatch_q;
  reg [8:0] argLatch_q;
  reg [8:0] nextInstr_q;
  reg fetchStep_q;
  reg [2:0] shState_q;
  reg wrPend_q;
  reg rdPend_q;
  reg [7:0] phAddr_q;

  reg [5:0] opcodeHold_d;
  reg [8:0] operandField_d;
  reg [8:0] indexWord_d;
  reg [14:0] memBuf_d;
  reg [8:0] addrLatch_d;
  reg [8:0] argLatch_d;
  reg [8:0] nextInstr_d;
  reg fetchStep_d;
  reg incrSelect_d;
  reg [2:0] shState_d;

  wire [3:0] opCode = opcodeHold_q[5:2];
  wire [1:0] variant = opcodeHold_q[1:0];
  wire kBit = opcodeHold_q[1];
  wire bBit = opcodeHold_q[0];
  wire lowCodes = opCode <= `CODE_LAST_LOW;
  wire [8:0] adderSum = addrLatch_q + {8'h00, incrSelect};
  wire countZero = memBuf_q[8:0] == 9'h000;
  wire isShift = opCode == `CODE_10 || opCode == `CODE_11;

  reg [3:0] rangeD;
  reg [3:0] digitD;
  reg [3:0] variantD;
  reg [15:0] codeD;
  integer i;

  always @*
  begin
    rangeD = dec2(opcodeHold_q[5:4]);
    digitD = dec2(opcodeHold_q[3:2]);
    variantD = dec2(opcodeHold_q[1:0]);
    for (i = 0; i < 16; i = i + 1)
      codeD[i] = rangeD[i / 4] & digitD[i % 4];
  end

  wire sharedD = codeD[`CODE_13] | codeD[`CODE_17];
  wire xferD = sharedD | (codeD[`CODE_06] & ~bBit);
  wire clrIncr = lowCodes & ~kBit & ~fetchStep_q;

  wire accept = hsel & htrans[1] & hready;
  wire wrCtrl = wrHit(wrPend_q, phAddr_q, `OFS_CTRL);
  wire wrInstr = wrHit(wrPend_q, phAddr_q, `OFS_INSTR);
  wire wrIndex = wrHit(wrPend_q, phAddr_q, `OFS_INDEX);
  wire wrMemBuf = wrHit(wrPend_q, phAddr_q, `OFS_MEMBUF);
  wire wrAddr = wrHit(wrPend_q, phAddr_q, `OFS_ADDR);
  wire wrNext = wrHit(wrPend_q, phAddr_q, `OFS_NEXT);
  wire startCmd = wrCtrl & hwdata[`CTRL_START];
  wire ldIdxCmd = wrCtrl & hwdata[`CTRL_LDIDX];
  wire add2NextCmd = wrCtrl & hwdata[`CTRL_ADD2NEXT];
  wire add2ArgCmd = wrCtrl & hwdata[`CTRL_ADD2ARG];
  wire add2BufCmd = wrCtrl & hwdata[`CTRL_ADD2BUF];
  wire op2ArgCmd = wrCtrl & hwdata[`CTRL_OP2ARG];
  wire idxIncCmd = wrCtrl & hwdata[`CTRL_IDXINC];
  wire shiftCmd = wrCtrl & hwdata[`CTRL_SHIFT];
  wire next2AddrCmd = wrCtrl & hwdata[`CTRL_NEXT2ADDR];

  // bus phase tracking; reads wait one cycle so read data comes from a flop
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      phAddr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      hresp <= 1'b0;
      wrPend_q <= accept & hwrite;
      if (rdPend_q)
      begin
        rdPend_q <= 1'b0;
        hreadyout <= 1'b1;
        case (phAddr_q)
          `OFS_INSTR: hrdata <= {17'h0, opcodeHold_q, operandField_q};
          `OFS_CTRL: hrdata <= {31'h0, fetchStep_q};
          `OFS_INDEX: hrdata <= {23'h0, indexWord_q};
          `OFS_MEMBUF: hrdata <= {17'h0, memBuf_q};
          `OFS_ADDR: hrdata <= {23'h0, addrLatch_q};
          `OFS_ARG: hrdata <= {23'h0, argLatch_q};
          `OFS_NEXT: hrdata <= {23'h0, nextInstr_q};
          `OFS_DECODE: hrdata <= {4'h0, codeD, variantD, digitD, rangeD};
          `OFS_STATUS: hrdata <= {26'h0, shState_q == SH_IDLE, countZero,
                                  xferD, sharedD, fetchStep_q, incrSelect};
          default: hrdata <= 32'h00000000;
        endcase
      end
      else if (accept & ~hwrite)
      begin
        rdPend_q <= 1'b1;
        hreadyout <= 1'b0;
      end
      if (accept)
        phAddr_q <= haddr[7:0];
    end
  end

  // next values; a bus write wins over an internal load
  always @*
  begin
    opcodeHold_d = opcodeHold_q;
    operandField_d = operandField_q;
    if (wrInstr)
    begin
      opcodeHold_d = hwdata[14:9];
      operandField_d = hwdata[8:0];
    end
    fetchStep_d = fetchStep_q;
    if (wrCtrl)
    begin
      fetchStep_d = hwdata[`CTRL_FETCH];
    end
    incrSelect_d = incrSelect;
    if (startCmd)
    begin
      incrSelect_d = 1'b1;
    end
    else if (clrIncr)
    begin
      incrSelect_d = 1'b0;
    end
    indexWord_d = indexWord_q;
    if (wrIndex)
    begin
      indexWord_d = hwdata[8:0];
    end
    else if (idxIncCmd && opCode == `CODE_06 && variant == `VAR_3)
    begin
      indexWord_d = adderSum;
    end
    nextInstr_d = nextInstr_q;
    if (wrNext)
    begin
      nextInstr_d = hwdata[8:0];
    end
    else if (add2NextCmd)
    begin
      nextInstr_d = adderSum;
    end
    argLatch_d = argLatch_q;
    if (add2ArgCmd)
    begin
      argLatch_d = adderSum;
    end
    else if (op2ArgCmd & xferD)
    begin
      argLatch_d = operandField_q;
    end
    shState_d = shState_q;
    case (shState_q)
      SH_IDLE:
      begin
        if (shiftCmd & isShift & ~countZero)
        begin
          shState_d = SH_LOAD;
        end
      end
      SH_LOAD:
      begin
        shState_d = SH_STORE;
      end
      SH_STORE:
      begin
        shState_d = SH_IDLE;
      end
      default:
      begin
        shState_d = SH_IDLE;
      end
    endcase
    memBuf_d = memBuf_q;
    if (wrMemBuf)
    begin
      memBuf_d = hwdata[14:0];
    end
    else if (shState_q == SH_STORE || add2BufCmd)
    begin
      memBuf_d[8:0] = ~adderSum;
    end
    addrLatch_d = addrLatch_q;
    if (wrAddr)
    begin
      addrLatch_d = hwdata[8:0];
    end
    else if (shState_q == SH_LOAD)
    begin
      addrLatch_d = ~memBuf_q[8:0];
    end
    else if (ldIdxCmd && bBit && (lowCodes || opCode == `CODE_17))
    begin
      addrLatch_d = indexWord_q + operandField_q;
    end
    else if (ldIdxCmd)
    begin
      addrLatch_d = operandField_q;
    end
    else if (next2AddrCmd)
    begin
      addrLatch_d = nextInstr_q;
    end
  end

  // register loads and datapath transfers
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      opcodeHold_q <= 6'h00;
      operandField_q <= 9'h000;
      indexWord_q <= 9'h000;
      memBuf_q <= 15'h0000;
      addrLatch_q <= 9'h000;
      argLatch_q <= 9'h000;
      nextInstr_q <= 9'h000;
      fetchStep_q <= 1'b0;
      incrSelect <= `RST_INCR;
      shState_q <= SH_IDLE;
    end
    else
    begin
      opcodeHold_q <= opcodeHold_d;
      operandField_q <= operandField_d;
      indexWord_q <= indexWord_d;
      memBuf_q <= memBuf_d;
      addrLatch_q <= addrLatch_d;
      argLatch_q <= argLatch_d;
      nextInstr_q <= nextInstr_d;
      fetchStep_q <= fetchStep_d;
      incrSelect <= incrSelect_d;
      shState_q <= shState_d;
    end
  end

  // decode outputs, held in flops and refreshed every cycle
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rangeHit <= 4'h0;
      digitHit <= 4'h0;
      variantHit <= 4'h0;
      codeHit <= 16'h0000;
      shared1317 <= 1'b0;
      xferEnable <= 1'b0;
      operandMode <= 1'b0;
      indexFlag <= 1'b0;
      shiftDone <= 1'b0;
    end
    else
    begin
      rangeHit <= rangeD;
      digitHit <= digitD;
      variantHit <= variantD;
      codeHit <= codeD;
      shared1317 <= sharedD;
      xferEnable <= xferD;
      operandMode <= kBit;
      indexFlag <= bBit;
      shiftDone <= isShift & countZero;
    end
  end

endmodule

// file: opdec_assertions.sv
// port assertions for the opcode decoder
`timescale 1ns/1ns
module opdec_assertions (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] rangeHit,
  input wire [3:0] digitHit,
  input wire [3:0] variantHit,
  input wire [15:0] codeHit,
  input wire shared1317,
  input wire xferEnable,
  input wire operandMode,
  input wire indexFlag,
  input wire shiftDone
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  function automatic [1:0] enc(input [3:0] v);
    enc = {v[3] | v[2], v[3] | v[1]};
  endfunction
  sequence rdTaken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rdWait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (rdTaken |=> rdWait) else $error("read wait");
  a_resp_okay: assert property (!hresp) else $error("resp");
  a_range_hot: assert property (!$past(sys_rst) |-> $onehot(rangeHit))
    else $error("range");
  a_digit_hot: assert property (!$past(sys_rst) |-> $onehot(digitHit))
    else $error("digit");
  a_variant_hot: assert property (!$past(sys_rst) |-> $onehot(variantHit))
    else $error("var");
  a_code_pair: assert property (!$past(sys_rst) |-> codeHit ==
    16'h1 << {enc(rangeHit), enc(digitHit)}) else $error("code");
  a_shared_codes: assert property (shared1317 == (codeHit[11] | codeHit[15]))
    else $error("shared");
  a_xfer_codes: assert property (xferEnable == (shared1317 | codeHit[6] & !indexFlag))
    else $error("xfer");
  a_mode_bits: assert property (!$past(sys_rst) |->
    {operandMode, indexFlag} == enc(variantHit)) else $error("mode");
  a_shift_code: assert property (shiftDone |-> codeHit[8] | codeHit[9])
    else $error("shift");
endmodule
bind opcode_decode_and_address_incrementer opdec_assertions chk (.mclk(mclk), .sys_rst(sys_rst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .rangeHit(rangeHit), .digitHit(digitHit), .variantHit(variantHit),
  .codeHit(codeHit), .shared1317(shared1317), .xferEnable(xferEnable),
  .operandMode(operandMode), .indexFlag(indexFlag), .shiftDone(shiftDone));

// file: bus_master.sv
// bus master standing in for the timing chain
`timescale 1ns/1ns
module bus_master (
  input wire mclk,
  input wire hreadyout,
  input wire [31:0] hrdata,
  output logic [1:0] htrans,
  output logic [31:0] haddr,
  output logic hwrite,
  output logic [31:0] hwdata
);
  initial
  begin
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  task wt;
    begin
      @(posedge mclk);
      while (!hreadyout) @(posedge mclk);
    end
  endtask
  task ap(input [7:0] a, input w);
    begin
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wt;
      htrans <= 2'h0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      ap(a, 1'b1);
      hwdata <= d;
      wt;
      // released data lines do not keep their value
      hwdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      ap(a, 1'b0);
      wt;
      d = hrdata;
    end
  endtask
endmodule

// file: tb_top.sv
// testbench for the opcode decoder and address adder
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic hwrite, hreadyout, hresp, shared1317, xferEnable, operandMode, indexFlag, incrSelect;
  logic shiftDone, s;
  logic [3:0] rangeHit, digitHit, variantHit;
  logic [15:0] codeHit;
  logic [5:0] op;
  logic [31:0] dexp;
  int failures = 0;
  int n_compared = 0;
  logic [14:0] ins [0:3] = '{15'h0A23, 15'h0823, 15'h7A23, 15'h3223};
  logic [8:0] adr [0:3] = '{9'h123, 9'h023, 9'h123, 9'h023};
  always #5 mclk = ~mclk;
  bus_master bm (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .htrans(htrans),
    .haddr(haddr), .hwrite(hwrite), .hwdata(hwdata));
  opcode_decode_and_address_incrementer uut (.mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rangeHit(rangeHit), .digitHit(digitHit), .variantHit(variantHit), .codeHit(codeHit),
    .shared1317(shared1317), .xferEnable(xferEnable), .operandMode(operandMode),
    .indexFlag(indexFlag), .incrSelect(incrSelect), .shiftDone(shiftDone));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared++;
      if (g !== e)
      begin
        failures++;
        $display("ERROR %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    logic [31:0] v;
    begin
      bm.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
    end
  endtask
  task final_report;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    failures++;
    final_report;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      op = i[5:0];
      s = op[5:2] == 4'hB || op[5:2] == 4'hF;
      dexp = {4'h0, 16'h1 << op[5:2], 4'h1 << op[1:0], 4'h1 << op[3:2], 4'h1 << op[5:4]};
      bm.wr(8'h00, {17'h0, op, 9'h0});
      rc(8'h1C, dexp);
      chk("hits", dexp, {4'h0, codeHit, variantHit, digitHit, rangeHit});
      chk("shared", s, shared1317);
      chk("xfer", s | (op[5:2] == 4'h6 && !op[0]), xferEnable);
      chk("mode", op[1:0], {operandMode, indexFlag});
    end
    $display("decode test done");
    bm.wr(8'h00, 32'h3600);
    bm.wr(8'h10, 32'h1FF);
    bm.wr(8'h04, 32'h2);
    @(posedge mclk);
    chk("incr", 1, incrSelect);
    bm.wr(8'h04, 32'h8);
    rc(8'h18, 32'h0);
    bm.wr(8'h10, 32'h44);
    bm.wr(8'h04, 32'h80);
    rc(8'h08, 32'h45);
    bm.wr(8'h04, 32'h20);
    rc(8'h0C, 32'h1BA);
    bm.wr(8'h00, 32'h55);
    bm.wr(8'h04, 32'h4);
    bm.wr(8'h04, 32'h10);
    chk("incr", 0, incrSelect);
    rc(8'h14, 32'h55);
    bm.wr(8'h04, 32'h3);
    bm.wr(8'h04, 32'h0);
    chk("incr", 1, incrSelect);
    repeat (2) @(posedge mclk);
    chk("incr", 0, incrSelect);
    $display("adder test done");
    bm.wr(8'h08, 32'h100);
    for (int k = 0; k < 4; k++)
    begin
      bm.wr(8'h00, {17'h0, ins[k]});
      bm.wr(8'h04, 32'h4);
      rc(8'h10, {23'h0, adr[k]});
    end
    bm.wr(8'h00, 32'h58AB);
    bm.wr(8'h04, 32'h40);
    rc(8'h14, 32'hAB);
    bm.wr(8'h00, 32'h4000);
    bm.wr(8'h0C, 32'h3);
    bm.wr(8'h04, 32'h2);
    for (int k = 2; k >= -1; k--)
    begin
      bm.wr(8'h04, 32'h100);
      repeat (3) @(posedge mclk);
      rc(8'h0C, k < 0 ? 0 : k);
      chk("done", k <= 0, shiftDone);
    end
    chk("done", 1, shiftDone);
    rc(8'h40, 32'h0);
    $display("index and shift test done");
    final_report;
  end
endmodule
